//--- shared/swbm_regs.svh
`ifndef SWBM_REGS_SVH
`define SWBM_REGS_SVH

// Register byte offsets
`define SWBM_A_CFG 8'h00
`define SWBM_A_DIV 8'h04
`define SWBM_A_CTRL 8'h08
`define SWBM_A_DATA 8'h0c
`define SWBM_A_FLAG 8'h10
`define SWBM_A_FEN 8'h14

// Configuration fields
`define SWBM_CFG_LONG 0
`define SWBM_CFG_BB 1
`define SWBM_CFG_EXTPU 2
`define SWBM_CFG_SPU 3
`define SWBM_CFG_BIT 4
`define SWBM_CFG_OD 5
`define SWBM_CFG_INTPU 6
`define SWBM_CFG_RST 7'h00

// Control and status fields
`define SWBM_CTL_RST 0
`define SWBM_CTL_SRA 1
`define SWBM_CTL_BBOUT 2
`define SWBM_CTL_PRES 3
`define SWBM_CTL_LINE 4
`define SWBM_CTL_BUSY 5

// Event flag fields
`define SWBM_FL_RDONE 0
`define SWBM_FL_TXD 1
`define SWBM_FL_RXR 2
`define SWBM_FL_ERR 3
`define SWBM_FL_PRES 4

// Peripheral clock 100 MHz, divided to the 1 MHz tick
`define SWBM_DIV_RST 8'h64

// Bus timing in microseconds, standard and overdrive
`define SWBM_TICK_PER_US 1
`define SWBM_US_RST_LOW_STD 480
`define SWBM_US_RST_SAMP_STD 550
`define SWBM_US_RST_END_STD 960
`define SWBM_US_LOW_STD 6
`define SWBM_US_LL_LOW_STD 8
`define SWBM_US_SAMP_STD 15
`define SWBM_US_LL_SAMP_STD 22
`define SWBM_US_ZERO_STD 60
`define SWBM_US_SLOT_STD 65
`define SWBM_US_RST_LOW_OD 48
`define SWBM_US_RST_SAMP_OD 56
`define SWBM_US_RST_END_OD 96
`define SWBM_US_LOW_OD 1
`define SWBM_US_LL_LOW_OD 2
`define SWBM_US_SAMP_OD 2
`define SWBM_US_LL_SAMP_OD 3
`define SWBM_US_ZERO_OD 8
`define SWBM_US_SLOT_OD 10

// Microseconds to tick counts
`define SWBM_CNT(us) (10'((us) * `SWBM_TICK_PER_US))

`endif

//--- shared/swbm_pkg.sv
package swbm_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RST,
    ST_SLOT
  } swbm_state_t;

  typedef logic [9:0] swbm_us_t;

endpackage : swbm_pkg

//--- shared/swbm_core_if.sv
`timescale 1ns/100ps
interface swbm_core_if;
  logic [7:0] divisor;
  logic tick;
  logic line;

  modport div (input divisor, output tick);
  modport syn (output line);
  modport core (output divisor, input tick, input line);
endinterface : swbm_core_if

//--- logic/swbm_tick_div.sv
`timescale 1ns/100ps
module swbm_tick_div (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Divisor in, tick out
  swbm_core_if.div cif
);

  logic pclk_en;
  logic [7:0] cnt;

  // Peripheral clock rate is half the system clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pclk_en <= 1'b0;
    end else begin
      pclk_en <= ~pclk_en;
    end
  end

  // Divisor zero behaves as one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
      cif.tick <= 1'b0;
    end else begin
      cif.tick <= 1'b0;
      if (pclk_en) begin
        if (cnt + 8'h01 >= cif.divisor) begin
          cnt <= 8'h00;
          cif.tick <= 1'b1;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end

endmodule : swbm_tick_div

//--- logic/swbm_line_sync.sv
`timescale 1ns/100ps
module swbm_line_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw pin and synchronised level
  input wire logic pin_i,
  swbm_core_if.syn cif
);

  logic meta;

  // Idle bus reads high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b1;
      cif.line <= 1'b1;
    end else begin
      meta <= pin_i;
      cif.line <= meta;
    end
  end

endmodule : swbm_line_sync

//--- logic/swbm_master.sv
`timescale 1ns/100ps
`include "swbm_regs.svh"
// How it works
// - All slot and pulse timing counts a 1 MHz tick prescaled from the clock.
// - Tick is half the system clock divided by the microsecond divisor field.
// - One tick serves both speeds; no divisor change when switching.
// - Hardware times every slot in standard and overdrive mode.
// - Internal pullup enable bit drives the on-chip pullup output.
// - External pullup mode lets the master drive the pullup enable output.
// - Pullup enable output is active high for the strong external pullup.
// - Master sends a reset pulse and samples for a presence pulse.
// - Read and write slots run for one bit or a whole byte.
// - Search accelerator runs read, read, write triplets and flags discrepancies.
// - Flags for transmit done, receive ready, presence and line error.
// - Long-line timing and bit-bang direct drive modes exist.
// - Nobody drives the line high; only low or released.
// - Line is open drain and idles high through a pullup.
// - Only the master starts any bus activity.
// - Values go least significant bit first, one direction at a time.
// - Write one releases after minimum low; zero holds for the zero-low time (60 of 65 us, 8 of 10 in overdrive), then releases before slot end.
// - Slot widths follow the overdrive bit with the same sequencing.
module swbm_master (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Bus line pin
  input wire logic BUS_LINE_IO_I,
  output logic BUS_LINE_IO_O,
  output logic BUS_LINE_IO_OE_O,
  // Pullup controls
  output logic STRONG_PULLUP_ENABLE_OUT_O,
  output logic INT_PULLUP_EN_O,
  // Event output
  output logic IRQ_O
);

  swbm_core_if cif ();

  swbm_tick_div u_div (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .cif(cif.div)
  );

  swbm_line_sync u_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .pin_i(BUS_LINE_IO_I),
    .cif(cif.syn)
  );

  logic [6:0] cfg;
  logic [7:0] div;
  logic sra_en;
  logic bb_out;
  logic [4:0] flag;
  logic [4:0] fen;
  logic [7:0] rx_data;
  logic presence;
  swbm_pkg::swbm_state_t state;
  swbm_pkg::swbm_us_t cnt;
  logic [3:0] slots;
  logic [7:0] sh;
  logic [7:0] rx_sh;
  logic [7:0] sra_res;
  logic [1:0] ph;
  logic id_a;
  logic id_b;
  logic sra_run;
  logic bit_run;
  swbm_pkg::swbm_us_t t_low;
  swbm_pkg::swbm_us_t t_samp;
  swbm_pkg::swbm_us_t t_zero;
  swbm_pkg::swbm_us_t t_slot;
  swbm_pkg::swbm_us_t t_rl;
  swbm_pkg::swbm_us_t t_rs;
  swbm_pkg::swbm_us_t t_re;
  logic next_drive;
  logic [31:0] next_rdata;
  logic [7:0] next_sra;

  wire tick = cif.tick;
  wire line = cif.line;
  wire od = cfg[`SWBM_CFG_OD];
  wire ll = cfg[`SWBM_CFG_LONG];
  wire bb = cfg[`SWBM_CFG_BB];
  wire idle = state == swbm_pkg::ST_IDLE;

  assign cif.divisor = div;

  // APB decode, zero wait states
  wire wr = PSEL_I & PENABLE_I & PWRITE_I;
  wire a_cfg = PADDR_I == `SWBM_A_CFG;
  wire a_div = PADDR_I == `SWBM_A_DIV;
  wire a_ctrl = PADDR_I == `SWBM_A_CTRL;
  wire a_data = PADDR_I == `SWBM_A_DATA;
  wire a_flag = PADDR_I == `SWBM_A_FLAG;
  wire a_fen = PADDR_I == `SWBM_A_FEN;
  wire mapped = a_cfg | a_div | a_ctrl | a_data | a_flag | a_fen;

  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

  // Starts are refused while busy or in bit-bang mode
  wire start_rst = wr & a_ctrl & PWDATA_I[`SWBM_CTL_RST] & idle & ~bb;
  wire start_tx = wr & a_data & idle & ~bb;

  // Speed and line-length dependent widths from one tick
  always_comb begin
    if (od) begin
      t_low = ll ? `SWBM_CNT(`SWBM_US_LL_LOW_OD) : `SWBM_CNT(`SWBM_US_LOW_OD);
      t_samp = ll ? `SWBM_CNT(`SWBM_US_LL_SAMP_OD) : `SWBM_CNT(`SWBM_US_SAMP_OD);
      t_zero = `SWBM_CNT(`SWBM_US_ZERO_OD);
      t_slot = `SWBM_CNT(`SWBM_US_SLOT_OD);
      t_rl = `SWBM_CNT(`SWBM_US_RST_LOW_OD);
      t_rs = `SWBM_CNT(`SWBM_US_RST_SAMP_OD);
      t_re = `SWBM_CNT(`SWBM_US_RST_END_OD);
    end else begin
      t_low = ll ? `SWBM_CNT(`SWBM_US_LL_LOW_STD) : `SWBM_CNT(`SWBM_US_LOW_STD);
      t_samp = ll ? `SWBM_CNT(`SWBM_US_LL_SAMP_STD) : `SWBM_CNT(`SWBM_US_SAMP_STD);
      t_zero = `SWBM_CNT(`SWBM_US_ZERO_STD);
      t_slot = `SWBM_CNT(`SWBM_US_SLOT_STD);
      t_rl = `SWBM_CNT(`SWBM_US_RST_LOW_STD);
      t_rs = `SWBM_CNT(`SWBM_US_RST_SAMP_STD);
      t_re = `SWBM_CNT(`SWBM_US_RST_END_STD);
    end
  end

  wire slot_end = (state == swbm_pkg::ST_SLOT) & tick & (cnt == t_slot - 10'h001);
  wire samp_now = (state == swbm_pkg::ST_SLOT) & tick & (cnt == t_samp);
  wire rst_samp = (state == swbm_pkg::ST_RST) & tick & (cnt == t_rs);
  wire rst_end = (state == swbm_pkg::ST_RST) & tick & (cnt == t_re - 10'h001);
  wire last_slot = slots == 4'h1;

  // Search choice: follow the only answer, else the software direction
  wire dir = (id_a ^ id_b) ? id_a : sh[0];
  wire disc = ~id_a & ~id_b;
  wire wbit = sra_run ? ((ph == 2'h2) ? dir : 1'b1) : sh[0];
  assign next_sra = {disc, sra_res[7:5], dir, sra_res[3:1]};

  // Configuration and divisor
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      cfg <= `SWBM_CFG_RST;
      div <= `SWBM_DIV_RST;
    end else if (wr & a_cfg) begin
      cfg <= PWDATA_I[6:0];
    end else if (wr & a_div) begin
      div <= PWDATA_I[7:0];
    end
  end

  // Control bits and flag enables
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      sra_en <= 1'b0;
      bb_out <= 1'b1;
      fen <= 5'h00;
    end else begin
      if (wr & a_ctrl) begin
        sra_en <= PWDATA_I[`SWBM_CTL_SRA];
        bb_out <= PWDATA_I[`SWBM_CTL_BBOUT];
      end
      if (wr & a_fen) begin
        fen <= PWDATA_I[4:0];
      end
    end
  end

  // Sequencer
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      state <= swbm_pkg::ST_IDLE;
    end else begin
      case (state)
        swbm_pkg::ST_IDLE: begin
          if (start_rst) begin
            state <= swbm_pkg::ST_RST;
          end else if (start_tx) begin
            state <= swbm_pkg::ST_SLOT;
          end
        end
        swbm_pkg::ST_RST: begin
          if (rst_end) begin
            state <= swbm_pkg::ST_IDLE;
          end
        end
        swbm_pkg::ST_SLOT: begin
          if (slot_end & last_slot) begin
            state <= swbm_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= swbm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Microsecond counter within a pulse or slot
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      cnt <= 10'h000;
    end else if (idle | slot_end | rst_end) begin
      cnt <= 10'h000;
    end else if (tick) begin
      cnt <= cnt + 10'h001;
    end
  end

  // Slot count and transmit shifter, low bit first
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      slots <= 4'h0;
      sh <= 8'h00;
      ph <= 2'h0;
      sra_run <= 1'b0;
      bit_run <= 1'b0;
    end else if (start_tx) begin
      sra_run <= sra_en;
      bit_run <= cfg[`SWBM_CFG_BIT] & ~sra_en;
      slots <= sra_en ? 4'hc : (cfg[`SWBM_CFG_BIT] ? 4'h1 : 4'h8);
      sh <= PWDATA_I[7:0];
      ph <= 2'h0;
    end else if (slot_end) begin
      slots <= slots - 4'h1;
      if (!sra_run) begin
        sh <= {1'b0, sh[7:1]};
      end else if (ph == 2'h2) begin
        ph <= 2'h0;
        sh <= {1'b0, sh[7:1]};
      end else begin
        ph <= ph + 2'h1;
      end
    end
  end

  // Line sampling and received data
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      id_a <= 1'b0;
      id_b <= 1'b0;
      rx_sh <= 8'h00;
      sra_res <= 8'h00;
      rx_data <= 8'h00;
    end else begin
      if (samp_now) begin
        if (!sra_run) begin
          rx_sh <= {line, rx_sh[7:1]};
        end else if (ph == 2'h0) begin
          id_a <= line;
        end else if (ph == 2'h1) begin
          id_b <= line;
        end
      end
      if (slot_end & sra_run & (ph == 2'h2)) begin
        sra_res <= next_sra;
      end
      if (slot_end & last_slot) begin
        if (sra_run) begin
          rx_data <= next_sra;
        end else if (bit_run) begin
          rx_data <= {7'h00, rx_sh[7]};
        end else begin
          rx_data <= rx_sh;
        end
      end
    end
  end

  // Presence is the line low at the sample point after reset
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      presence <= 1'b0;
    end else if (start_rst) begin
      presence <= 1'b0;
    end else if (rst_samp) begin
      presence <= ~line;
    end
  end

  // Sticky event flags; a new event beats a clear in the same cycle
  wire [4:0] ev;
  assign ev[`SWBM_FL_RDONE] = rst_end;
  assign ev[`SWBM_FL_TXD] = slot_end & last_slot;
  assign ev[`SWBM_FL_RXR] = slot_end & last_slot;
  assign ev[`SWBM_FL_ERR] = idle & ~bb & tick & ~line;
  assign ev[`SWBM_FL_PRES] = rst_end & presence;

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      flag <= 5'h00;
    end else begin
      flag <= (flag & ~((wr & a_flag) ? PWDATA_I[4:0] : 5'h00)) | ev;
    end
  end

  // Line drive: low or released only
  always_comb begin
    case (state)
      swbm_pkg::ST_IDLE: next_drive = bb & ~bb_out;
      swbm_pkg::ST_RST: next_drive = cnt < t_rl;
      swbm_pkg::ST_SLOT: next_drive = (cnt < t_low) | (~wbit & (cnt < t_zero));
      default: next_drive = 1'b0;
    endcase
  end

  assign BUS_LINE_IO_O = 1'b0;

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      BUS_LINE_IO_OE_O <= 1'b0;
      STRONG_PULLUP_ENABLE_OUT_O <= 1'b0;
      INT_PULLUP_EN_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      BUS_LINE_IO_OE_O <= next_drive;
      STRONG_PULLUP_ENABLE_OUT_O <= cfg[`SWBM_CFG_EXTPU] & cfg[`SWBM_CFG_SPU] & ~next_drive;
      INT_PULLUP_EN_O <= cfg[`SWBM_CFG_INTPU];
      IRQ_O <= |(flag & fen);
    end
  end

  // Read data captured in the setup phase
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (1'b1)
      a_cfg: next_rdata[6:0] = cfg;
      a_div: next_rdata[7:0] = div;
      a_ctrl: next_rdata[5:0] = {~idle, line, presence, bb_out, sra_en, 1'b0};
      a_data: next_rdata[7:0] = rx_data;
      a_flag: next_rdata[4:0] = flag;
      a_fen: next_rdata[4:0] = fen;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I & ~PENABLE_I) begin
      PRDATA_O <= next_rdata;
    end
  end

  // Checks
  wire may_drive = ~idle | bb;

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RESET_I);

  tick_pulse_a: assert property (tick |=> !tick)
    else $error("tick lasted more than one cycle");
  idle_release_a: assert property (idle && !bb |=> !BUS_LINE_IO_OE_O)
    else $error("line driven while idle");
  start_only_a: assert property ($rose(BUS_LINE_IO_OE_O) |-> $past(may_drive))
    else $error("line pulled low with no operation");
  rst_low_a: assert property (state == swbm_pkg::ST_RST && cnt < t_rl |=> BUS_LINE_IO_OE_O)
    else $error("reset pulse released early");
  zero_hold_a: assert property (state == swbm_pkg::ST_SLOT && !wbit && cnt < t_zero |=> BUS_LINE_IO_OE_O)
    else $error("zero slot released early");
  one_release_a: assert property (state == swbm_pkg::ST_SLOT && wbit && cnt >= t_low |=> !BUS_LINE_IO_OE_O)
    else $error("one slot held too long");
  pullup_mode_a: assert property (STRONG_PULLUP_ENABLE_OUT_O |-> $past(cfg[`SWBM_CFG_EXTPU]) && !BUS_LINE_IO_OE_O)
    else $error("strong pullup outside its mode");
  tx_done_a: assert property (slot_end && last_slot |=> flag[`SWBM_FL_TXD] && idle)
    else $error("byte end not flagged");
  sra_slots_a: assert property (start_tx && sra_en |=> slots == 4'hc && sra_run)
    else $error("search needs twelve slots");
  pres_flag_a: assert property (rst_end && presence |=> flag[`SWBM_FL_PRES] && flag[`SWBM_FL_RDONE])
    else $error("presence not flagged");

  cover property (rst_end && presence);
  cover property (slot_end && last_slot && sra_run);
  cover property (state == swbm_pkg::ST_SLOT && od && samp_now);

endmodule : swbm_master

//--- verification/swbm_slave_model.sv
`timescale 1ns/100ps
module swbm_slave_model #(
  parameter int TICK_NS = 10
) (
  // Bus line and speed
  input wire logic line_i,
  input wire logic od_i,
  // Behaviour controls
  input wire logic present_i,
  input wire logic talk_i,
  input wire logic [7:0] tx_byte_i,
  // Open-drain pull and received byte
  output logic pull_o,
  output logic [7:0] rx_byte_o
);
  realtime t_fall;
  int idx;
  bit armed;
  initial begin
    pull_o = 1'b0;
    rx_byte_o = 8'h00;
    idx = 0;
    t_fall = 0;
    armed = 1'b0;
  end
  // Reacts only to a falling edge made by someone else
  always @(negedge line_i) begin
    if (!pull_o) begin
      t_fall = $realtime;
      armed = 1'b1;
      if (talk_i) begin
        pull_o = ~tx_byte_i[idx];
        idx = (idx + 1) % 8;
        #((od_i ? 5 : 45) * TICK_NS) pull_o = 1'b0;
      end else begin
        #((od_i ? 4 : 30) * TICK_NS) rx_byte_o = {line_i, rx_byte_o[7:1]};
      end
    end
  end
  // A long low is a bus reset, answered at the speed in use
  always @(posedge line_i) begin
    if (armed && !pull_o && ($realtime - t_fall) >= (od_i ? 30 : 300) * TICK_NS) begin
      armed = 1'b0;
      idx = 0;
      if (present_i) begin
        #((od_i ? 2 : 15) * TICK_NS) pull_o = 1'b1;
        #((od_i ? 24 : 240) * TICK_NS) pull_o = 1'b0;
      end
    end
    armed = 1'b0;
  end
endmodule : swbm_slave_model

//--- verification/tb.sv
`timescale 1ns/100ps
`include "swbm_regs.svh"
module tb;
  logic clk, rst, psel, penable, pwrite, od, present, talk, ext_pull, e, drv_hi;
  logic [7:0] paddr, s_tx;
  logic [31:0] pwdata, r;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, oe, line_o, spe, ipu, irq, s_pull, line;
  wire logic [7:0] s_rx;
  int fails, checks, run, last, pulses, per, sp;
  // Wired-AND line with pull-up
  assign line = (oe ? line_o : 1'b1) & ~s_pull & ~ext_pull;
  swbm_master u_dut (
    .SYS_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .BUS_LINE_IO_I(line), .BUS_LINE_IO_O(line_o), .BUS_LINE_IO_OE_O(oe),
    .STRONG_PULLUP_ENABLE_OUT_O(spe), .INT_PULLUP_EN_O(ipu), .IRQ_O(irq)
  );
  swbm_slave_model u_slave (
    .line_i(line), .od_i(od), .present_i(present), .talk_i(talk), .tx_byte_i(s_tx),
    .pull_o(s_pull), .rx_byte_o(s_rx)
  );
  // Low pulse length in cycles and pulse count
  always @(posedge clk) begin
    if (oe === 1'b1) begin
      run <= run + 1;
      if (line_o !== 1'b0) drv_hi <= 1'b1;
    end else if (run != 0) begin
      last <= run;
      run <= 0;
      pulses <= pulses + 1;
    end
  end
  task automatic summarize();
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic rng(input string n, input int x);
    checks++;
    if (last < x * per - 3 || last > x * per + 3) begin
      fails++;
      $display("MISMATCH %s expected %0d seen %0d", n, x * per, last);
    end
  endtask : rng
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, r);
  endtask : rd
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, `SWBM_A_CTRL, 32'h0);
      n++;
    end while (r[5] !== 1'b0 && n < 4000);
    if (n >= 4000) begin
      fails++;
      summarize();
    end
  endtask : idle
  task automatic settle(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    repeat (2) @(posedge clk);
  endtask : settle
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rst, psel, penable, pwrite, od, present, talk, ext_pull, drv_hi} = 9'h108;
    paddr = 8'h00;
    pwdata = 32'h0;
    s_tx = 8'h00;
    {fails, checks, run, last, pulses} = '0;
    per = 2;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("idle_out", 32'h0, {28'h0, oe, spe, ipu, irq});
    rd("cfg_rst", `SWBM_A_CFG, 32'h0);
    rd("div_rst", `SWBM_A_DIV, {24'h0, `SWBM_DIV_RST});
    rd("ctrl_rst", `SWBM_A_CTRL, 32'h14);
    rd("flag_rst", `SWBM_A_FLAG, 32'h0);
    chk("slverr_ok", 32'h0, {31'h0, e});
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, {r[30:0], e});
    wr(`SWBM_A_DIV, 32'h1);
    wr(`SWBM_A_FEN, 32'h10);
    for (sp = 0; sp < 2; sp++) begin
      od = sp[0];
      wr(`SWBM_A_CFG, {26'h0, sp[0], 5'h0});
      wr(`SWBM_A_FLAG, 32'h1f);
      wr(`SWBM_A_CTRL, 32'h5);
      idle();
      rng("rst_low", sp ? 48 : 480);
      rd("rst_flags", `SWBM_A_FLAG, 32'h11);
      chk("irq_on", 32'h1, {31'h0, irq});
      settle(`SWBM_A_FLAG, 32'h1f);
      chk("irq_off", 32'h0, {31'h0, irq});
      wr(`SWBM_A_DATA, 32'ha5);
      idle();
      chk("slave_rx", 32'ha5, {24'h0, s_rx});
      rng("one_low", sp ? 1 : 6);
      rd("tx_flags", `SWBM_A_FLAG, 32'h06);
      s_tx = 8'h3c;
      talk = 1'b1;
      wr(`SWBM_A_DATA, 32'hff);
      idle();
      talk = 1'b0;
      rd("rx_byte", `SWBM_A_DATA, 32'h3c);
      wr(`SWBM_A_CFG, {26'h0, sp[0], 5'h10});
      wr(`SWBM_A_DATA, 32'h0);
      idle();
      rng("zero_low", sp ? 8 : 60);
      wr(`SWBM_A_CFG, {26'h0, sp[0], 5'h11});
      wr(`SWBM_A_DATA, 32'h1);
      idle();
      rng("long_low", sp ? 2 : 8);
      rd("bit_rx", `SWBM_A_DATA, 32'h1);
      wr(`SWBM_A_CFG, {26'h0, sp[0], 5'h0});
      wr(`SWBM_A_CTRL, 32'h6);
      pulses = 0;
      // Slave answers give a discrepancy, then single answers of each polarity
      s_tx = 8'h8c;
      talk = 1'b1;
      wr(`SWBM_A_DATA, 32'hf);
      idle();
      talk = 1'b0;
      chk("srch_slots", 32'd12, pulses);
      rd("srch_data", `SWBM_A_DATA, 32'h13);
      wr(`SWBM_A_CTRL, 32'h4);
    end
    od = 1'b0;
    present = 1'b0;
    wr(`SWBM_A_CFG, 32'h0);
    wr(`SWBM_A_FLAG, 32'h1f);
    wr(`SWBM_A_CTRL, 32'h5);
    idle();
    rd("no_pres", `SWBM_A_FLAG, 32'h01);
    present = 1'b1;
    ext_pull <= 1'b1;
    repeat (10) @(posedge clk);
    ext_pull <= 1'b0;
    rd("line_err", `SWBM_A_FLAG, 32'h09);
    settle(`SWBM_A_CFG, 32'h4c);
    chk("pullups", 32'h3, {30'h0, spe, ipu});
    rd("cfg_rw", `SWBM_A_CFG, 32'h4c);
    settle(`SWBM_A_CFG, 32'h08);
    chk("pe_off", 32'h0, {30'h0, spe, ipu});
    wr(`SWBM_A_CFG, 32'h02);
    settle(`SWBM_A_CTRL, 32'h0);
    chk("bb_low", 32'h1, {31'h0, oe});
    settle(`SWBM_A_CTRL, 32'h4);
    chk("bb_rel", 32'h0, {31'h0, oe});
    wr(`SWBM_A_CFG, 32'h10);
    wr(`SWBM_A_DIV, 32'h2);
    per = 4;
    wr(`SWBM_A_DATA, 32'h0);
    // A start while busy must be ignored, so the zero slot stands
    wr(`SWBM_A_DATA, 32'h1);
    idle();
    rng("div2_zero", 60);
    chk("drive_hi", 32'h0, {31'h0, drv_hi});
    summarize();
  end
endmodule : tb
